// ===== hdl/dfs_pkg.sv
// Behaviour
// - Option-board watchdog fault after more than 200 ms without messages.
// - Speed-loss fault when speed error exceeds limit longer than set time.
// - Speed error time of 99.9 disables speed-loss detection.
// - Torque-limit timeout fault when torque limiting outlasts set time.
// - Torque limit time of 999 disables torque-limit timeout detection.
// - Speed-loss and torque timeout detection only in vector modes 3 or 4.
// - Latching fault drops no-fault relay and stops all PWM pulses.
// - Latching fault shows code on displays and flashes the error LED.
// - Latching fault saves code, overload, time counters, backup reference; not one that latches while another is latched.
// - Checksum, self-diag inhibit drive; self-diag also shows and flashes.
// - Conflict blocks PWM, drops no-error relay, energises error relay.
// - Keypad link fault: drive runs, keypad commands dropped, code shown.
// - Keypad link fault is never written to fault history.
// - Keypad link fault clears itself when keypad messages return.
// - Overtemp and aux undervoltage clear from any reset source; the keypad key only while the keypad link is up.
// - Conflict raises its fault and shows a cause and correction help.
`default_nettype none
package dfs_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS       = 1_000_000;   // 1 ms base tick
  localparam int unsigned TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WDOG_MS       = 200;
  localparam int unsigned FLASH_MS_DEF  = 250;
  localparam logic [19:0] MS_PER_TENTH  = 20'h00064;
  localparam logic [19:0] MS_PER_SEC    = 20'h003E8;
  localparam logic [19:0] MS_MAX        = 20'hFFFFF;
  // ==========================================================
  // Settings encodings and reset values
  localparam logic [9:0]  TIME_OFF      = 10'h3E7;     // 99.9 / 999
  localparam logic [2:0]  MODE_VEC_SL   = 3'h3;
  localparam logic [2:0]  MODE_VEC_ENC  = 3'h4;
  // ==========================================================
  // Fault codes shown on the displays
  localparam logic [7:0]  C_NONE = 8'h00;
  localparam logic [7:0]  C_CHK  = 8'h09;
  localparam logic [7:0]  C_CONF = 8'h18;
  localparam logic [7:0]  C_KP   = 8'h1F;
  localparam logic [7:0]  C_OT   = 8'h20;
  localparam logic [7:0]  C_SPD  = 8'h21;
  localparam logic [7:0]  C_TRQ  = 8'h22;
  localparam logic [7:0]  C_DIAG = 8'h29;
  localparam logic [7:0]  C_UV   = 8'h46;
  localparam logic [7:0]  C_WD   = 8'h47;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]  A_MODE    = 8'h00;
  localparam logic [7:0]  A_SPD_LIM = 8'h04;
  localparam logic [7:0]  A_SPD_TIM = 8'h08;
  localparam logic [7:0]  A_TRQ_TIM = 8'h0C;
  localparam logic [7:0]  A_STATUS  = 8'h10;
  localparam logic [7:0]  A_IRQ_ST  = 8'h14;
  localparam logic [7:0]  A_IRQ_CLR = 8'h18;
  localparam logic [7:0]  A_IRQ_EN  = 8'h1C;
  // ==========================================================
  // Non-volatile record word indices
  localparam logic [2:0]  N_CODE = 3'h0;
  localparam logic [2:0]  N_OVL  = 3'h1;
  localparam logic [2:0]  N_PWR  = 3'h2;
  localparam logic [2:0]  N_ENA  = 3'h3;
  localparam logic [2:0]  N_REF  = 3'h4;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SV_IDLE  = 2'b01,
    SV_WRITE = 2'b10
  } dfs_save_type;

  typedef struct packed {
    logic keypad_key;
    logic auto_reset;
    logic digital_in;
    logic serial;
    logic fieldbus;
  } dfs_reset_src_type;

  typedef struct packed {
    logic [31:0]  pre;
    logic [19:0]  wd_ms;
    logic [19:0]  spd_ms;
    logic [19:0]  trq_ms;
    logic [8:0]   fl_ms;
    logic         flash;
    logic [4:0]   lat;       // uv, wd, ot, trq, spd
    logic [7:0]   code;
    logic         kp_q;
    logic         cf_q;
    logic         in_q;
    logic [2:0]   mode;
    logic         ref_bk;
    logic [15:0]  spd_lim;
    logic [9:0]   spd_time;
    logic [9:0]   trq_time;
    logic [7:0]   irq_st;
    logic [7:0]   irq_en;
    logic         irq;
    logic         dph;
    logic         dwr;
    logic [7:0]   daddr;
    logic         hready;
    logic [31:0]  hrdata;
    dfs_save_type sv;
    logic         nvm_we;
    logic [2:0]   nvm_idx;
    logic [31:0]  nvm_wdata;
    logic         pwm_en;
    logic         nf_relay;
    logic         err_relay;
    logic         inhibit;
    logic [7:0]   disp;
    logic         help;
    logic [7:0]   cause;
    logic         err_led;
    logic         kp_valid;
    logic [7:0]   kp_cmd;
  } dfs_state_type;

  localparam dfs_state_type ST_RESET = '{
    spd_time: TIME_OFF, trq_time: TIME_OFF, hready: 1'b1,
    sv: SV_IDLE, default: '0};
endpackage
`default_nettype wire

// ===== hdl/dfs_supervisor.sv
`default_nettype none
module dfs_supervisor
  import dfs_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF,
  parameter int unsigned FLASH_MS = FLASH_MS_DEF
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [15:0]       speed_actual,
  input  wire logic [15:0]       speed_command,
  input  wire logic              torque_limit_active,
  input  wire logic              option_board_present,
  input  wire logic              option_board_rx,
  input  wire logic              motor_overtemp_in,
  input  wire logic              aux_uv_in,
  input  wire logic              checksum_fail,
  input  wire logic              self_diag_fail,
  input  wire logic              param_conflict_in,
  input  wire logic [7:0]        conflict_cause,
  input  wire logic              keypad_link_ok,
  input  wire logic              keypad_cmd_valid,
  input  wire logic [7:0]        keypad_cmd,
  input  wire dfs_reset_src_type reset_src,
  input  wire logic [31:0]       overload_state,
  input  wire logic [31:0]       powered_time_counter,
  input  wire logic [31:0]       enabled_time_counter,
  input  wire logic [31:0]       keypad_speed_ref,
  input  wire logic              nvm_ready,
  output logic                   nvm_we,
  output logic      [2:0]        nvm_index,
  output logic      [31:0]       nvm_wdata,
  output logic                   pwm_enable,
  output logic                   no_fault_relay,
  output logic                   error_relay,
  output logic                   drive_inhibit,
  output logic      [7:0]        led_code,
  output logic      [7:0]        lcd_code,
  output logic                   lcd_help,
  output logic      [7:0]        lcd_help_cause,
  output logic                   error_led,
  output logic                   keypad_cmd_valid_out,
  output logic      [7:0]        keypad_cmd_out,
  output logic                   irq
);

  // ==========================================================
  // Helpers

  // Millisecond timer: cleared while idle, saturates instead of wrapping
  function automatic logic [19:0] ms_step(input logic [19:0] c,
                                          input logic        run,
                                          input logic        tk);
    if (!run)
      return '0;
    if (tk && c != MS_MAX)
      return c + 20'h1;
    return c;
  endfunction

  // Setting in its own unit turned into milliseconds
  function automatic logic [19:0] ms_limit(input logic [9:0]  s,
                                           input logic [19:0] unit);
    return 20'(s * unit);
  endfunction

  // One word of the fault record
  function automatic logic [31:0] rec_word(input logic [2:0] i,
                                           input logic [7:0] cd);
    case (i)
      N_CODE:  return {24'h000000, cd};
      N_OVL:   return overload_state;
      N_PWR:   return powered_time_counter;
      N_ENA:   return enabled_time_counter;
      N_REF:   return keypad_speed_ref;
      default: return 32'h00000000;
    endcase
  endfunction

  // ==========================================================
  // State

  dfs_state_type r;
  dfs_state_type n;

  logic        tick;
  logic        vec;
  logic [15:0] spd_err;
  logic        spd_run;
  logic        trq_run;
  logic        wd_run;
  logic [4:0]  trip;
  logic [4:0]  ev;
  logic        rst_req;
  logic [7:0]  new_code;
  logic        internal;
  logic        kp_fault;
  logic [7:0]  irq_ev;
  logic [7:0]  clr;
  logic        ap;
  logic [31:0] rd;

  // ==========================================================
  // Next-state logic
  always_comb begin
    n = r;

    // Millisecond base tick
    tick  = (r.pre == 32'(TICK_CYC - 1));
    n.pre = tick ? 32'h0 : r.pre + 32'h1;

    // Timed detectors, stopped with their timer cleared while their fault is latched
    vec = (r.mode == MODE_VEC_SL) || (r.mode == MODE_VEC_ENC);
    spd_err = (speed_actual > speed_command) ?
              speed_actual - speed_command : speed_command - speed_actual;
    spd_run = vec && (r.spd_time != TIME_OFF)
              && (spd_err > r.spd_lim) && !r.lat[0];
    trq_run = vec && (r.trq_time != TIME_OFF)
              && torque_limit_active && !r.lat[1];
    wd_run  = option_board_present && !option_board_rx && !r.lat[3];
    n.spd_ms = ms_step(r.spd_ms, spd_run, tick);
    n.trq_ms = ms_step(r.trq_ms, trq_run, tick);
    n.wd_ms  = ms_step(r.wd_ms, wd_run, tick);
    trip[0] = spd_run && (r.spd_ms > ms_limit(r.spd_time,
                                              MS_PER_TENTH));
    trip[1] = trq_run && (r.trq_ms > ms_limit(r.trq_time,
                                              MS_PER_SEC));
    trip[2] = motor_overtemp_in;
    trip[3] = wd_run && (r.wd_ms > 20'(WDOG_MS));
    trip[4] = aux_uv_in;
    ev = trip & ~r.lat;

    // Reset sources; the keypad key is a keypad command too
    rst_req = (reset_src.keypad_key && keypad_link_ok)
              || reset_src.auto_reset || reset_src.digital_in
              || reset_src.serial || reset_src.fieldbus;

    // Latch: a new trip in the reset cycle still latches
    n.lat = (r.lat & ~{5{rst_req}}) | ev;
    if (ev[3])
      new_code = C_WD;
    else if (ev[1])
      new_code = C_TRQ;
    else if (ev[0])
      new_code = C_SPD;
    else if (ev[2])
      new_code = C_OT;
    else
      new_code = C_UV;
    if ((r.lat == 5'h00 || rst_req) && ev != 5'h00)
      n.code = new_code;
    else if (n.lat == 5'h00)
      n.code = C_NONE;

    // Drive permissions and relays
    internal    = checksum_fail || self_diag_fail;
    n.inhibit   = internal || param_conflict_in;
    n.pwm_en    = (r.lat == 5'h00) && !internal
                  && !param_conflict_in;
    n.nf_relay  = (r.lat == 5'h00) && !internal && !param_conflict_in;
    n.err_relay = (r.lat != 5'h00) || internal || param_conflict_in;

    // Displays: internal faults outrank latched ones, keypad last
    kp_fault = !keypad_link_ok;
    if (self_diag_fail)
      n.disp = C_DIAG;
    else if (checksum_fail)
      n.disp = C_CHK;
    else if (param_conflict_in)
      n.disp = C_CONF;
    else if (r.lat != 5'h00)
      n.disp = r.code;
    else if (kp_fault)
      n.disp = C_KP;
    else
      n.disp = C_NONE;
    n.help  = param_conflict_in;
    n.cause = param_conflict_in ? conflict_cause : 8'h00;

    // Error LED flash
    if (tick) begin
      if (r.fl_ms == 9'(FLASH_MS - 1)) begin
        n.fl_ms = 9'h000;
        n.flash = !r.flash;
      end else begin
        n.fl_ms = r.fl_ms + 9'h001;
      end
    end
    n.err_led = ((r.lat != 5'h00) || self_diag_fail) && r.flash;

    // Keypad commands dropped while the link is down
    n.kp_valid = keypad_cmd_valid && keypad_link_ok;
    n.kp_cmd   = keypad_cmd;

    // Fault record save; only latching faults start one
    case (r.sv)
      SV_IDLE: begin
        if (r.lat == 5'h00 && ev != 5'h00) begin
          n.sv        = SV_WRITE;
          n.nvm_we    = 1'b1;
          n.nvm_idx   = N_CODE;
          n.nvm_wdata = rec_word(N_CODE, new_code);
        end
      end
      SV_WRITE: begin
        if (nvm_ready) begin
          if (r.nvm_idx == N_REF || (r.nvm_idx == N_ENA && !r.ref_bk)) begin
            n.sv     = SV_IDLE;
            n.nvm_we = 1'b0;
          end else begin
            n.nvm_idx   = r.nvm_idx + 3'h1;
            n.nvm_wdata = rec_word(r.nvm_idx + 3'h1, r.code);
          end
        end
      end
      default: begin
        n.sv     = SV_IDLE;
        n.nvm_we = 1'b0;
      end
    endcase

    // Interrupt events: rising edges of internal, conflict and keypad faults, plus each new latch
    n.kp_q = kp_fault;
    n.cf_q = param_conflict_in;
    n.in_q = internal;
    irq_ev = {internal && !r.in_q, param_conflict_in && !r.cf_q,
              kp_fault && !r.kp_q, ev};

    // Bus address phase; read data is fetched here
    ap = hsel && htrans[1] && hready;
    n.dph   = ap;
    n.dwr   = hwrite;
    n.daddr = haddr[7:0];
    case (haddr[7:0])
      A_MODE:    rd = {27'h0, r.ref_bk, 1'b0, r.mode};
      A_SPD_LIM: rd = {16'h0000, r.spd_lim};
      A_SPD_TIM: rd = {22'h000000, r.spd_time};
      A_TRQ_TIM: rd = {22'h000000, r.trq_time};
      A_STATUS:  rd = {15'h0000, r.sv == SV_WRITE, r.inhibit,
                       r.cf_q, r.kp_q, r.lat, r.disp};
      A_IRQ_ST:  rd = {24'h000000, r.irq_st};
      A_IRQ_EN:  rd = {24'h000000, r.irq_en};
      default:   rd = 32'h00000000;
    endcase
    n.hrdata = (ap && !hwrite) ? rd : 32'h00000000;

    // Bus data phase writes
    clr = 8'h00;
    if (r.dph && r.dwr) begin
      case (r.daddr)
        A_MODE: begin
          n.mode   = hwdata[2:0];
          n.ref_bk = hwdata[4];
        end
        A_SPD_LIM: n.spd_lim  = hwdata[15:0];
        A_SPD_TIM: n.spd_time = hwdata[9:0];
        A_TRQ_TIM: n.trq_time = hwdata[9:0];
        A_IRQ_CLR: clr        = hwdata[7:0];
        A_IRQ_EN:  n.irq_en   = hwdata[7:0];
        default: begin
        end
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle
    n.irq_st = (r.irq_st & ~clr) | irq_ev;
    n.irq    = |(r.irq_st & r.irq_en);
  end

  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      r <= ST_RESET;
    else
      r <= n;
  end

  // ==========================================================
  // Outputs, all from flops except hresp, which is tied off
  assign hrdata               = r.hrdata;
  assign hreadyout            = r.hready;
  assign hresp                = 1'b0;        // Always OKAY
  assign nvm_we               = r.nvm_we;
  assign nvm_index            = r.nvm_idx;
  assign nvm_wdata            = r.nvm_wdata;
  assign pwm_enable           = r.pwm_en;
  assign no_fault_relay       = r.nf_relay;
  assign error_relay          = r.err_relay;
  assign drive_inhibit        = r.inhibit;
  assign led_code             = r.disp;
  assign lcd_code             = r.disp;
  assign lcd_help             = r.help;
  assign lcd_help_cause       = r.cause;
  assign error_led            = r.err_led;
  assign keypad_cmd_valid_out = r.kp_valid;
  assign keypad_cmd_out       = r.kp_cmd;
  assign irq                  = r.irq;

endmodule
`default_nettype wire

// ===== bench/dfs_supervisor_props.sv
`default_nettype none
// ==========================================================
// Checker: fault responses seen at the supervisor ports
module dfs_chk
  import dfs_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              motor_overtemp_in,
  input wire dfs_reset_src_type reset_src,
  input wire logic              param_conflict_in,
  input wire logic              self_diag_fail,
  input wire logic              keypad_link_ok,
  input wire logic              keypad_cmd_valid,
  input wire logic [7:0]        keypad_cmd,
  input wire logic              keypad_cmd_valid_out,
  input wire logic [7:0]        keypad_cmd_out,
  input wire logic              nvm_we,
  input wire logic              nvm_ready,
  input wire logic [2:0]        nvm_index,
  input wire logic [31:0]       nvm_wdata,
  input wire logic              pwm_enable,
  input wire logic              no_fault_relay,
  input wire logic              error_relay,
  input wire logic              drive_inhibit,
  input wire logic [7:0]        led_code,
  input wire logic              lcd_help
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Named steps; a reset pulse is kept out of the fault step so a
  // clear in flight cannot be mistaken for a missed stop
  sequence s_ot;
    motor_overtemp_in && reset_src == '0;
  endsequence
  sequence s_stop;
    !pwm_enable && !no_fault_relay;
  endsequence
  sequence s_code_taken;
    nvm_we && nvm_ready && nvm_index == N_CODE;
  endsequence
  AST_OT_STOP: assert property (s_ot |-> ##2 s_stop)
    else $error("overtemp did not stop drive");
  AST_CONF_BLOCK: assert property (param_conflict_in [*3] |->
    !pwm_enable && error_relay && !no_fault_relay && lcd_help)
    else $error("conflict response missing");
  AST_DIAG_INHIBIT: assert property (self_diag_fail [*3] |->
    drive_inhibit && !pwm_enable && led_code == C_DIAG)
    else $error("self diagnosis response missing");
  AST_KP_PASS: assert property (keypad_link_ok && keypad_cmd_valid |=>
    keypad_cmd_valid_out && keypad_cmd_out == $past(keypad_cmd))
    else $error("keypad command not passed");
  AST_KP_DROP: assert property (!keypad_link_ok |=> !keypad_cmd_valid_out)
    else $error("keypad command passed while link down");
  AST_NVM_HOLD: assert property (nvm_we && !nvm_ready |=>
    nvm_we && $stable(nvm_index) && $stable(nvm_wdata))
    else $error("record word not held");
  AST_NVM_ORDER: assert property (s_code_taken |=>
    nvm_we && nvm_index == N_OVL)
    else $error("record order wrong");
  AST_NO_KP_SAVE: assert property (nvm_we && nvm_index == N_CODE |->
    nvm_wdata[7:0] != C_KP)
    else $error("keypad fault recorded");
endmodule

bind dfs_supervisor dfs_chk i_dfs_chk (
  .hclk(hclk), .hresetn(hresetn), .motor_overtemp_in(motor_overtemp_in),
  .reset_src(reset_src), .param_conflict_in(param_conflict_in),
  .self_diag_fail(self_diag_fail), .keypad_link_ok(keypad_link_ok),
  .keypad_cmd_valid(keypad_cmd_valid), .keypad_cmd(keypad_cmd),
  .keypad_cmd_valid_out(keypad_cmd_valid_out),
  .keypad_cmd_out(keypad_cmd_out), .nvm_we(nvm_we), .nvm_ready(nvm_ready),
  .nvm_index(nvm_index), .nvm_wdata(nvm_wdata), .pwm_enable(pwm_enable),
  .no_fault_relay(no_fault_relay), .error_relay(error_relay),
  .drive_inhibit(drive_inhibit), .led_code(led_code), .lcd_help(lcd_help));
`default_nettype wire

// ===== bench/dfs_partner.sv
`default_nettype none
// ==========================================================
// Far side: option board messages and the record memory
module dfs_partner (
  input  wire logic        hclk,
  input  wire logic        talk,
  input  wire logic        slow,
  output logic             option_board_rx,
  input  wire logic        nvm_we,
  input  wire logic [2:0]  nvm_index,
  input  wire logic [31:0] nvm_wdata,
  output logic             nvm_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]  div = 7'h00;
  int unsigned nwords = 0;
  logic [31:0] words [0:7];
  // One message every 128 cycles; slow memory accepts only every
  // fourth cycle so the record has to wait on it
  assign option_board_rx = talk && div == 7'h00;
  assign nvm_ready = !slow || div[1:0] == 2'h3;
  // Keep every accepted word by its index
  always @(posedge hclk) begin
    div <= div + 7'h01;
    if (nvm_we && nvm_ready) begin
      words[nvm_index] <= nvm_wdata;
      nwords <= nwords + 1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/dfs_supervisor_tb.sv
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  fail_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); \
  end end
module dfs_supervisor_tb
  import dfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCYC = 20;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, rec = '0, nvm_wdata;
  logic        hreadyout, hresp, irq, rx, nvm_ready, nvm_we, kvo, e0;
  logic [15:0] spd_act = 16'h0100, spd_cmd = 16'h0100;
  logic        trq = 1'h0, ot = 1'h0, uv = 1'h0, chk = 1'h0, diag = 1'h0;
  logic        conf = 1'h0, kp_ok = 1'h1, kp_v = 1'h0, ob = 1'h0;
  logic        talk = 1'h0, slow = 1'h1, pwm, nfr, err_r, inh, help, eled;
  logic [7:0]  cause = 8'h00, kp_c = 8'h00, led, lcd, hcause, kco;
  logic [2:0]  nvm_index;
  dfs_reset_src_type rsrc = '0;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n0;
  // ==========================================================
  // Clock, design and far side
  always #2.5 hclk = ~hclk;
  dfs_supervisor #(.TICK_CYC(TCYC), .FLASH_MS(2)) i_dfs_supervisor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .speed_actual(spd_act), .speed_command(spd_cmd),
    .torque_limit_active(trq), .option_board_present(ob),
    .option_board_rx(rx), .motor_overtemp_in(ot), .aux_uv_in(uv),
    .checksum_fail(chk), .self_diag_fail(diag), .param_conflict_in(conf),
    .conflict_cause(cause), .keypad_link_ok(kp_ok),
    .keypad_cmd_valid(kp_v), .keypad_cmd(kp_c), .reset_src(rsrc),
    .overload_state(rec), .powered_time_counter(rec + 32'h1),
    .enabled_time_counter(rec + 32'h2), .keypad_speed_ref(rec + 32'h3),
    .nvm_ready(nvm_ready), .nvm_we(nvm_we), .nvm_index(nvm_index),
    .nvm_wdata(nvm_wdata), .pwm_enable(pwm), .no_fault_relay(nfr),
    .error_relay(err_r), .drive_inhibit(inh), .led_code(led),
    .lcd_code(lcd), .lcd_help(help), .lcd_help_cause(hcause),
    .error_led(eled), .keypad_cmd_valid_out(kvo), .keypad_cmd_out(kco),
    .irq(irq));
  dfs_partner i_dfs_partner (.hclk(hclk), .talk(talk), .slow(slow),
    .option_board_rx(rx), .nvm_we(nvm_we), .nvm_index(nvm_index),
    .nvm_wdata(nvm_wdata), .nvm_ready(nvm_ready));
  // ==========================================================
  // Shared tasks: cycles, one bus transfer, waits, reset pulse
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wait_led(input logic [7:0] exp, input int lim);
    for (int k = 0; k < lim && led !== exp; k++) @(posedge hclk);
    `CHK(led, exp);
  endtask
  task automatic flash_chk;
    e0 = eled;
    for (int k = 0; k < 100 && eled === e0; k++) @(posedge hclk);
    `CHK(eled, ~e0);
  endtask
  task automatic pulse_src(input int b);
    rsrc <= dfs_reset_src_type'(5'h01 << b);
    @(posedge hclk);
    rsrc <= '0;
    cyc(4);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    ahb(1'h0, A_TRQ_TIM, 32'h0);
    `CHK(rd, {22'h0, TIME_OFF});
    ahb(1'h0, 8'h40, 32'h0);
    `CHK(rd, 32'h0);
    ahb(1'h1, A_SPD_LIM, 32'h0000000A);
    ahb(1'h0, A_SPD_LIM, 32'h0);
    `CHK(rd, 32'h0000000A);
    `CHK({pwm, nfr}, 2'h3);
    `CHK(hresp, 1'h0);
  endtask
  // Latch overtemp or undervoltage, check responses, clear per source
  task automatic t_latch;
    logic [7:0] c;
    logic [31:0] b;
    ahb(1'h1, A_MODE, 32'h00000010);
    for (int i = 0; i < 5; i++) begin
      c = i[0] ? C_UV : C_OT;
      b = i[0] ? 32'h10 : 32'h04;
      ahb(1'h1, A_IRQ_EN, (i == 4) ? 32'h0 : b);
      n0 = i_dfs_partner.nwords;
      rec <= 32'hA5000000 + 32'(i);
      if (i[0]) uv <= 1'h1;
      else ot <= 1'h1;
      wait_led(c, 10);
      `CHK({lcd, pwm, nfr, err_r}, {c, 3'h1});
      @(posedge hclk);
      ot <= 1'h0;
      uv <= 1'h0;
      flash_chk;
      cyc(60);
      `CHK(i_dfs_partner.nwords - n0, 5);
      `CHK(i_dfs_partner.words[0], {24'h0, c});
      for (int j = 1; j < 5; j++) `CHK(i_dfs_partner.words[j], rec + j - 1);
      ahb(1'h0, A_STATUS, 32'h0);
      `CHK(rd, {b[23:0], c});
      `CHK(irq, i != 4);
      ahb(1'h0, A_IRQ_ST, 32'h0);
      `CHK(rd, b);
      ahb(1'h1, A_IRQ_CLR, b);
      cyc(2);
      `CHK(irq, 1'h0);
      `CHK(pwm, 1'h0);
      pulse_src(i);
      `CHK({led, pwm, nfr}, {8'h00, 2'h3});
    end
  endtask
  // Speed or torque condition held; no trip before lo ms, trip within hi ms after that
  task automatic t_trip(input logic [2:0] m, input logic [9:0] st,
      input logic [9:0] tt, input logic [15:0] sa, input logic t,
      input int lo, input int hi, input logic [7:0] exp);
    ahb(1'h1, A_MODE, {29'h0, m});
    ahb(1'h1, A_SPD_TIM, {22'h0, st});
    ahb(1'h1, A_TRQ_TIM, {22'h0, tt});
    spd_act <= sa;
    trq <= t;
    cyc(lo * TCYC);
    `CHK(led, 8'h00);
    wait_led(exp, hi * TCYC);
    spd_act <= 16'h0100;
    trq <= 1'h0;
    cyc(40);
    pulse_src(1);
    `CHK(led, 8'h00);
  endtask
  task automatic t_wd;
    talk <= 1'h1;
    ob <= 1'h1;
    cyc(1000);
    `CHK(led, 8'h00);
    talk <= 1'h0;
    cyc(185 * TCYC);
    `CHK(led, 8'h00);
    wait_led(C_WD, 30 * TCYC);
    ob <= 1'h0;
    cyc(40);
    pulse_src(2);
  endtask
  task automatic t_keypad;
    n0 = i_dfs_partner.nwords;
    kp_ok <= 1'h0;
    kp_v <= 1'h1;
    kp_c <= 8'h5A;
    wait_led(C_KP, 10);
    `CHK({kvo, pwm}, 2'h1);
    cyc(40);
    `CHK(i_dfs_partner.nwords - n0, 0);
    kp_ok <= 1'h1;
    cyc(3);
    `CHK({kvo, kco}, {1'h1, 8'h5A});
    kp_v <= 1'h0;
    wait_led(8'h00, 10);
  endtask
  task automatic t_conf;
    cause <= 8'h2C;
    conf <= 1'h1;
    wait_led(C_CONF, 10);
    `CHK({help, hcause, pwm, nfr, err_r}, {9'h12C, 3'h1});
    conf <= 1'h0;
    chk <= 1'h1;
    wait_led(C_CHK, 10);
    `CHK({inh, pwm}, 2'h2);
    chk <= 1'h0;
    diag <= 1'h1;
    wait_led(C_DIAG, 10);
    flash_chk;
    diag <= 1'h0;
    wait_led(8'h00, 10);
  endtask
  // ==========================================================
  // Verdict, main sequence and hang watchdog
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    hresetn <= 1'h1;
    cyc(2);
    t_regs;
    t_latch;
    t_trip(3'h3, 10'h001, TIME_OFF, 16'h0114, 1'h0, 95, 20, C_SPD);
    t_trip(3'h4, 10'h001, TIME_OFF, 16'h010A, 1'h0, 130, 0, 8'h00);
    t_trip(3'h4, TIME_OFF, TIME_OFF, 16'h0114, 1'h0, 130, 0, 8'h00);
    t_trip(3'h2, 10'h001, 10'h001, 16'h0114, 1'h1, 130, 0, 8'h00);
    t_trip(3'h4, TIME_OFF, 10'h001, 16'h0100, 1'h1, 990, 20, C_TRQ);
    t_wd;
    t_keypad;
    t_conf;
    complete_run;
  end
  initial begin
    #300_000;
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
